// *** src/apc_cfg.svh ***
// Constants of the audio processor control block: offsets, fields, resets, timing.
// Assumes an 8-bit register port and a 40 MHz ref_clk_i.
//
// Summary of operation
// - Clearing processor enable zeroes code pointer
// - Load select toggling keeps code pointer
// - Setting enable starts loaded firmware
// - Command field, status, firmware event flag
// - 24-bit millisecond play time, three bytes
// - Low byte read latches whole counter
// - High byte write loads staged counter
// - Fast forward and rewind adjust time
// - Stop to play clears; pause holds
// - Baseband disable bypasses every treatment
// - Five-bit volume codes, all ones mutes
// - Muted channel still streams, zero unless mixing
// - Three equalizer bands, same gain coding
// - Equalizer disable keeps stored band gains
// - Bass boost adds 6 dB below 200 Hz
// - Surround acts on both channels
// - Band index selects readable bar level
// - Mixing adds recording ADC to output
// - DSP clip input sets clip flag
// - Eight flags, own enables, global enable
// - Enabled flag set raises interrupt request while global enable is set
// - Request flag: empty or half, clears full
// - Ready flag: full or half, clears empty
`ifndef APC_CFG_SVH
`define APC_CFG_SVH

`define APC_ADDR_W 8
`define APC_DATA_W 8
`define APC_PTR_W 16

`define APC_A_PCTRL 8'h00
`define APC_A_CMD 8'h01
`define APC_A_FWSTAT 8'h02
`define APC_A_IFLAGS 8'h03
`define APC_A_IEN 8'h04
`define APC_A_GIEN 8'h05
`define APC_A_TIM0 8'h06
`define APC_A_TIM1 8'h07
`define APC_A_TIM2 8'h08
`define APC_A_BBCTRL 8'h09
`define APC_A_RVOL 8'h0A
`define APC_A_LVOL 8'h0B
`define APC_A_BGAIN 8'h0C
`define APC_A_MGAIN 8'h0D
`define APC_A_TGAIN 8'h0E
`define APC_A_BGSEL 8'h0F
`define APC_A_BGLEV 8'h10
`define APC_A_SCTRL 8'h11
`define APC_A_SSTA0 8'h12
`define APC_A_SSTA1 8'h13
`define APC_A_SSTA2 8'h14
`define APC_A_DPORT 8'h15

`define APC_B_PEN 0
`define APC_B_LOAD 1
`define APC_B_FWEVT 7
`define APC_B_BBEN 0
`define APC_B_EQDIS 1
`define APC_B_BOOST 2
`define APC_B_SURR 3
`define APC_B_MIX 4
`define APC_B_GIEN 0
`define APC_F_REQ 0
`define APC_F_RDY 1
`define APC_F_CLIP 2
`define APC_F_GP_LO 3

`define APC_VOL_RST 5'h03
`define APC_VOL_MUTE 5'h1F
`define APC_EQ_LOW_HZ 750
`define APC_EQ_HIGH_HZ 3300
`define APC_BOOST_HZ 200
`define APC_BOOST_DB 6

`define APC_CLK_MHZ 40
`define APC_TICK_US 1000
`define APC_FF_STEP 24'h00000A

`endif

// *** src/apc_pkg.sv ***
// Types shared by the audio processor control block.
// Assumes apc_cfg.svh is on the include path.
`include "apc_cfg.svh"

package apc_pkg;

    typedef enum logic [2:0] {
        APC_STOP = 3'b000,
        APC_PLAY = 3'b001,
        APC_PAUSE = 3'b010,
        APC_FFWD = 3'b011,
        APC_REW = 3'b100
    } apc_mode_e;

    typedef struct packed {
        logic vol_active;
        logic eq_active;
        logic boost_active;
        logic surround_active;
        logic mix_active;
        logic [4:0] right_vol;
        logic [4:0] left_vol;
        logic [4:0] bass_gain;
        logic [4:0] mid_gain;
        logic [4:0] treble_gain;
    } apc_bb_cfg_s;

    typedef struct packed {
        logic valid;
        logic [15:0] right;
        logic [15:0] left;
    } apc_sample_s;

    typedef struct packed {
        logic wr;
        logic [`APC_PTR_W-1:0] addr;
        logic [`APC_DATA_W-1:0] data;
    } apc_code_wr_s;

endpackage : apc_pkg

// *** src/apc_top.sv ***
// Audio processor control: register port, firmware load, play time,
// baseband settings, sample mute stage and interrupt aggregation.
// Assumes a synchronous 8-bit register port and a DSP that reports
// clip, general events, bar levels and buffer fill as plain inputs.
`timescale 1ns/100ps
`default_nettype none
`include "apc_cfg.svh"

module apc_top
    import apc_pkg::*;
#(
    parameter int TICK_CYCLES = `APC_CLK_MHZ * `APC_TICK_US
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [`APC_ADDR_W-1:0] addr_i,
    input wire logic [`APC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`APC_DATA_W-1:0] rdata_o,
    input wire logic [`APC_DATA_W-1:0] fw_status_i,
    input wire logic fw_event_i,
    input wire logic [`APC_DATA_W-1:0] stream_status0_i,
    input wire logic [`APC_DATA_W-1:0] stream_status1_i,
    input wire logic [`APC_DATA_W-1:0] stream_status2_i,
    input wire apc_mode_e play_mode_i,
    input wire logic buf_write_mode_i,
    input wire logic buf_empty_i,
    input wire logic buf_half_i,
    input wire logic buf_full_i,
    input wire logic clip_i,
    input wire logic [4:0] gp_event_i,
    input wire logic [39:0] bar_levels_i,
    input wire apc_sample_s sample_i,
    input wire apc_sample_s mix_sample_i,
    output apc_sample_s sample_o,
    output apc_code_wr_s code_wr_o,
    output logic buf_wr_o,
    output logic [`APC_DATA_W-1:0] buf_wdata_o,
    output logic proc_run_o,
    output logic [6:0] fw_command_o,
    output logic [`APC_DATA_W-1:0] stream_control_o,
    output apc_bb_cfg_s bb_cfg_o,
    output logic irq_o
);

    function automatic logic hit(input logic [`APC_ADDR_W-1:0] a,
                                 input logic [`APC_ADDR_W-1:0] b);
        hit = (a == b);
    endfunction : hit

    function automatic logic [15:0] mute_sat(input logic mute,
                                             input logic [15:0] s,
                                             input logic [15:0] m,
                                             input logic mix);
        logic [16:0] sum;
        // Mute silences the processor only; the recording path still mixes in
        sum = (mute ? 17'h00000 : {s[15], s}) + {m[15], m};
        if (!mix) begin
            mute_sat = mute ? 16'h0000 : s;
        end else if (sum[16] != sum[15]) begin
            mute_sat = sum[16] ? 16'h8000 : 16'h7FFF;
        end else begin
            mute_sat = sum[15:0];
        end
    endfunction : mute_sat

    // Register state
    logic proc_en;
    logic load_sel;
    logic fw_evt;
    logic [6:0] cmd;
    logic [7:0] iflags;
    logic [7:0] ien;
    logic gien;
    logic [4:0] bbctrl;
    logic [4:0] vol_r;
    logic [4:0] vol_l;
    logic [4:0] gain_b;
    logic [4:0] gain_m;
    logic [4:0] gain_t;
    logic [2:0] bar_sel;
    logic [7:0] sctrl;
    logic [`APC_PTR_W-1:0] code_ptr;
    logic [23:0] play_time;
    logic [23:0] time_snap;
    logic [15:0] stage_lo_mid;
    logic [15:0] tick_cnt;
    apc_mode_e mode_q;

    // Decode
    wire wr_pctrl = wr_i && hit(addr_i, `APC_A_PCTRL);
    wire wr_cmd = wr_i && hit(addr_i, `APC_A_CMD);
    wire wr_iflags = wr_i && hit(addr_i, `APC_A_IFLAGS);
    wire wr_ien = wr_i && hit(addr_i, `APC_A_IEN);
    wire wr_gien = wr_i && hit(addr_i, `APC_A_GIEN);
    wire wr_tim0 = wr_i && hit(addr_i, `APC_A_TIM0);
    wire wr_tim1 = wr_i && hit(addr_i, `APC_A_TIM1);
    wire wr_tim2 = wr_i && hit(addr_i, `APC_A_TIM2);
    wire wr_bb = wr_i && hit(addr_i, `APC_A_BBCTRL);
    wire wr_rvol = wr_i && hit(addr_i, `APC_A_RVOL);
    wire wr_lvol = wr_i && hit(addr_i, `APC_A_LVOL);
    wire wr_bgain = wr_i && hit(addr_i, `APC_A_BGAIN);
    wire wr_mgain = wr_i && hit(addr_i, `APC_A_MGAIN);
    wire wr_tgain = wr_i && hit(addr_i, `APC_A_TGAIN);
    wire wr_bgsel = wr_i && hit(addr_i, `APC_A_BGSEL);
    wire wr_sctrl = wr_i && hit(addr_i, `APC_A_SCTRL);
    wire wr_dport = wr_i && hit(addr_i, `APC_A_DPORT);
    wire rd_tim0 = rd_i && hit(addr_i, `APC_A_TIM0);

    // Firmware loading only while halted; otherwise the port feeds the buffer
    wire code_load = wr_dport && load_sel && !proc_en;
    wire pen_clear = wr_pctrl && !wdata_i[`APC_B_PEN] && proc_en;
    wire [`APC_PTR_W-1:0] next_code_ptr =
        pen_clear ? {`APC_PTR_W{1'b0}} :
        code_load ? code_ptr + 16'h0001 : code_ptr;

    // Play time: a millisecond tick drives play and seek modes
    wire tick = (tick_cnt == 16'(TICK_CYCLES - 1));
    wire stop_to_play = (mode_q == APC_STOP) && (play_mode_i == APC_PLAY);
    wire [23:0] time_step =
        (play_mode_i == APC_PLAY) ? play_time + 24'h000001 :
        (play_mode_i == APC_FFWD) ? play_time + `APC_FF_STEP :
        (play_mode_i == APC_REW) ?
            ((play_time > `APC_FF_STEP) ? play_time - `APC_FF_STEP : 24'h000000) :
        play_time;
    wire [23:0] next_play_time =
        wr_tim2 ? {wdata_i, stage_lo_mid[15:8], stage_lo_mid[7:0]} :
        stop_to_play ? 24'h000000 :
        tick ? time_step : play_time;
    wire [23:0] next_time_snap = rd_tim0 ? play_time : time_snap;

    // Interrupt flags; hardware set wins over a software clear
    wire [4:0] gp_clr = wr_iflags ? wdata_i[7:3] : 5'h00;
    wire clip_clr = wr_iflags && wdata_i[`APC_F_CLIP];
    wire next_clip = clip_i || (iflags[`APC_F_CLIP] && !clip_clr);
    wire [4:0] next_gp = gp_event_i | (iflags[7:3] & ~gp_clr);
    wire next_req = buf_write_mode_i &&
        ((buf_empty_i || buf_half_i) ? 1'b1 : buf_full_i ? 1'b0 :
         iflags[`APC_F_REQ]);
    wire next_rdy = !buf_write_mode_i &&
        ((buf_full_i || buf_half_i) ? 1'b1 : buf_empty_i ? 1'b0 :
         iflags[`APC_F_RDY]);
    wire [7:0] next_iflags = {next_gp, next_clip, next_rdy, next_req};
    wire next_irq = gien && |(iflags & ien);
    wire next_fw_evt = fw_event_i || (fw_evt && !(wr_pctrl && wdata_i[`APC_B_FWEVT]));

    // Baseband: disable forces every treatment off
    wire bb_en = bbctrl[`APC_B_BBEN];
    wire mute_r = bb_en && (vol_r == `APC_VOL_MUTE);
    wire mute_l = bb_en && (vol_l == `APC_VOL_MUTE);
    wire mix_on = bb_en && bbctrl[`APC_B_MIX];
    apc_bb_cfg_s next_bb_cfg;
    assign next_bb_cfg.vol_active = bb_en;
    assign next_bb_cfg.eq_active = bb_en && !bbctrl[`APC_B_EQDIS];
    assign next_bb_cfg.boost_active = bb_en && bbctrl[`APC_B_BOOST];
    assign next_bb_cfg.surround_active = bb_en && bbctrl[`APC_B_SURR];
    assign next_bb_cfg.mix_active = mix_on;
    assign next_bb_cfg.right_vol = vol_r;
    assign next_bb_cfg.left_vol = vol_l;
    assign next_bb_cfg.bass_gain = gain_b;
    assign next_bb_cfg.mid_gain = gain_m;
    assign next_bb_cfg.treble_gain = gain_t;

    // Muted samples keep their slot so downstream timing is unchanged
    apc_sample_s next_sample;
    assign next_sample.valid = sample_i.valid;
    assign next_sample.right = mute_sat(mute_r, sample_i.right, mix_sample_i.right, mix_on);
    assign next_sample.left = mute_sat(mute_l, sample_i.left, mix_sample_i.left, mix_on);

    // Bar graph band pick
    logic [4:0] bar_bands [8];
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bar
            assign bar_bands[gi] = bar_levels_i[gi*5 +: 5];
        end
    endgenerate
    wire [4:0] bar_level = bar_bands[bar_sel];

    // Read mux; unmapped offsets read zero
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        case (addr_i)
            `APC_A_PCTRL: next_rdata = {fw_evt, 5'h00, load_sel, proc_en};
            `APC_A_CMD: next_rdata = {1'b0, cmd};
            `APC_A_FWSTAT: next_rdata = fw_status_i;
            `APC_A_IFLAGS: next_rdata = iflags;
            `APC_A_IEN: next_rdata = ien;
            `APC_A_GIEN: next_rdata = {7'h00, gien};
            `APC_A_TIM0: next_rdata = play_time[7:0];
            `APC_A_TIM1: next_rdata = time_snap[15:8];
            `APC_A_TIM2: next_rdata = time_snap[23:16];
            `APC_A_BBCTRL: next_rdata = {3'h0, bbctrl};
            `APC_A_RVOL: next_rdata = {3'h0, vol_r};
            `APC_A_LVOL: next_rdata = {3'h0, vol_l};
            `APC_A_BGAIN: next_rdata = {3'h0, gain_b};
            `APC_A_MGAIN: next_rdata = {3'h0, gain_m};
            `APC_A_TGAIN: next_rdata = {3'h0, gain_t};
            `APC_A_BGSEL: next_rdata = {5'h00, bar_sel};
            `APC_A_BGLEV: next_rdata = {3'h0, bar_level};
            `APC_A_SCTRL: next_rdata = sctrl;
            `APC_A_SSTA0: next_rdata = stream_status0_i;
            `APC_A_SSTA1: next_rdata = stream_status1_i;
            `APC_A_SSTA2: next_rdata = stream_status2_i;
            default: next_rdata = 8'h00;
        endcase
    end

    // Control registers
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            proc_en <= 1'b0;
            load_sel <= 1'b0;
            cmd <= 7'h00;
            ien <= 8'h00;
            gien <= 1'b0;
            sctrl <= 8'h00;
            bar_sel <= 3'h0;
        end else begin
            if (wr_pctrl) begin
                proc_en <= wdata_i[`APC_B_PEN];
                load_sel <= wdata_i[`APC_B_LOAD];
            end
            if (wr_cmd) begin
                cmd <= wdata_i[6:0];
            end
            if (wr_ien) begin
                ien <= wdata_i;
            end
            if (wr_gien) begin
                gien <= wdata_i[`APC_B_GIEN];
            end
            if (wr_sctrl) begin
                sctrl <= wdata_i;
            end
            if (wr_bgsel) begin
                bar_sel <= wdata_i[2:0];
            end
        end
    end

    // Baseband settings
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            bbctrl <= 5'h00;
            vol_r <= `APC_VOL_RST;
            vol_l <= `APC_VOL_RST;
            gain_b <= `APC_VOL_RST;
            gain_m <= `APC_VOL_RST;
            gain_t <= `APC_VOL_RST;
        end else begin
            if (wr_bb) begin
                bbctrl <= wdata_i[4:0];
            end
            if (wr_rvol) begin
                vol_r <= wdata_i[4:0];
            end
            if (wr_lvol) begin
                vol_l <= wdata_i[4:0];
            end
            if (wr_bgain) begin
                gain_b <= wdata_i[4:0];
            end
            if (wr_mgain) begin
                gain_m <= wdata_i[4:0];
            end
            if (wr_tgain) begin
                gain_t <= wdata_i[4:0];
            end
        end
    end

    // Play time
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            play_time <= 24'h000000;
            time_snap <= 24'h000000;
            stage_lo_mid <= 16'h0000;
            tick_cnt <= 16'h0000;
            mode_q <= APC_STOP;
        end else begin
            play_time <= next_play_time;
            time_snap <= next_time_snap;
            mode_q <= play_mode_i;
            tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
            if (wr_tim0) begin
                stage_lo_mid[7:0] <= wdata_i;
            end
            if (wr_tim1) begin
                stage_lo_mid[15:8] <= wdata_i;
            end
        end
    end

    // Flags, pointer, outputs
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            iflags <= 8'h00;
            fw_evt <= 1'b0;
            code_ptr <= {`APC_PTR_W{1'b0}};
            code_wr_o <= '0;
            buf_wr_o <= 1'b0;
            buf_wdata_o <= 8'h00;
            irq_o <= 1'b0;
            rdata_o <= 8'h00;
            sample_o <= '0;
            bb_cfg_o <= '0;
        end else begin
            iflags <= next_iflags;
            fw_evt <= next_fw_evt;
            code_ptr <= next_code_ptr;
            code_wr_o.wr <= code_load;
            code_wr_o.addr <= code_ptr;
            code_wr_o.data <= wdata_i;
            buf_wr_o <= wr_dport && !code_load;
            buf_wdata_o <= wdata_i;
            irq_o <= next_irq;
            rdata_o <= rd_i ? next_rdata : 8'h00;
            sample_o <= next_sample;
            bb_cfg_o <= next_bb_cfg;
        end
    end

    // Register flops drive these outputs directly
    assign proc_run_o = proc_en;
    assign fw_command_o = cmd;
    assign stream_control_o = sctrl;

endmodule : apc_top
`default_nettype wire

// *** verif/apc_assertions.sv ***
// Concurrent checks on the apc_top ports, bound at the foot.
// Assumes bb_cfg_o and sample_o register on the same edge.
`timescale 1ns/100ps
`default_nettype none
`include "apc_cfg.svh"
module apc_assertions
    import apc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [`APC_ADDR_W-1:0] addr_i,
    input wire logic [`APC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [`APC_DATA_W-1:0] rdata_o,
    input wire apc_sample_s sample_i,
    input wire apc_sample_s sample_o,
    input wire apc_code_wr_s code_wr_o,
    input wire logic buf_wr_o,
    input wire logic proc_run_o,
    input wire logic [6:0] fw_command_o,
    input wire apc_bb_cfg_s bb_cfg_o,
    input wire logic irq_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Clearing a set enable restarts the code pointer
    logic [15:0] exp_ptr;
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || (wr_i && addr_i == `APC_A_PCTRL && !wdata_i[`APC_B_PEN]
            && proc_run_o)) begin
            exp_ptr <= 16'h0000;
        end else if (code_wr_o.wr) begin
            exp_ptr <= code_wr_o.addr + 16'h0001;
        end
    end
    sequence s_dport_wr;
        wr_i && addr_i == `APC_A_DPORT;
    endsequence
    sequence s_gien_off;
        wr_i && addr_i == `APC_A_GIEN && !wdata_i[`APC_B_GIEN];
    endsequence
    a_read_data_window: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its cycle");
    a_command_follows: assert property (wr_i && addr_i == `APC_A_CMD
        |=> fw_command_o == $past(wdata_i[6:0]))
        else $error("command field not passed on");
    a_enable_follows: assert property (wr_i && addr_i == `APC_A_PCTRL
        |=> proc_run_o == $past(wdata_i[`APC_B_PEN]))
        else $error("processor enable not applied");
    a_port_route: assert property (s_dport_wr |=> code_wr_o.wr != buf_wr_o)
        else $error("data port write lost or doubled");
    a_load_while_idle: assert property (code_wr_o.wr |-> !proc_run_o)
        else $error("code written while running");
    a_code_ptr_track: assert property (code_wr_o.wr |-> code_wr_o.addr == exp_ptr)
        else $error("code pointer out of step");
    a_global_off: assert property (s_gien_off |-> ##2 !irq_o)
        else $error("irq with global enable off");
    a_bypass_bits: assert property (!bb_cfg_o.vol_active |-> !(bb_cfg_o.eq_active
        || bb_cfg_o.boost_active || bb_cfg_o.surround_active || bb_cfg_o.mix_active))
        else $error("treatment active in bypass");
    a_bypass_pass: assert property (!bb_cfg_o.vol_active && $stable(bb_cfg_o)
        && $past(sample_i.valid) |-> sample_o == $past(sample_i))
        else $error("bypass altered sample");
    a_stream_on: assert property ($past(sample_i.valid) |-> sample_o.valid)
        else $error("sample stream dropped");
    a_mute_zero: assert property (bb_cfg_o.vol_active && bb_cfg_o.right_vol == `APC_VOL_MUTE
        && !bb_cfg_o.mix_active && $stable(bb_cfg_o) && sample_o.valid
        |-> sample_o.right == 16'h0000)
        else $error("muted channel not zero");
endmodule : apc_assertions
bind apc_top apc_assertions u_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sample_i(sample_i), .sample_o(sample_o), .code_wr_o(code_wr_o), .buf_wr_o(buf_wr_o),
    .proc_run_o(proc_run_o), .fw_command_o(fw_command_o), .bb_cfg_o(bb_cfg_o), .irq_o(irq_o));
`default_nettype wire

// *** verif/apc_fw_model.sv ***
// Firmware side model: takes code bytes, answers status and bar levels.
// Assumes one code byte per wr pulse.
`timescale 1ns/100ps
`default_nettype none
module apc_fw_model
    import apc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire apc_code_wr_s code_wr_i,
    input wire logic [6:0] fw_command_i,
    input wire logic proc_run_i,
    output logic [7:0] fw_status_o,
    output logic [39:0] bar_levels_o,
    output logic [15:0] last_addr_o,
    output logic [7:0] last_data_o,
    output logic load_err_o
);
    // Echo keeps the status traceable to the last command
    assign fw_status_o = {1'b1, fw_command_i};
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            bar_levels_o[5*b +: 5] = 5'(3 * b + 1);
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            last_addr_o <= 16'h0000;
            last_data_o <= 8'h00;
            load_err_o <= 1'b0;
        end else if (code_wr_i.wr) begin
            last_addr_o <= code_wr_i.addr;
            last_data_o <= code_wr_i.data;
            load_err_o <= load_err_o | proc_run_i;
        end
    end
endmodule : apc_fw_model
`default_nettype wire

// *** verif/tb_audio_processor_control.sv ***
// Directed bench for apc_top with the firmware side model.
// Assumes TICK_CYCLES of 8 so play time moves quickly.
`timescale 1ns/100ps
`default_nettype none
`include "apc_cfg.svh"
module tb_audio_processor_control
    import apc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fw_evt = 1'b0;
    logic wmode = 1'b0;
    logic bempty = 1'b1;
    logic bfull = 1'b0;
    logic clip = 1'b0;
    logic [4:0] gp = 5'h00;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    apc_mode_e mode = APC_STOP;
    apc_sample_s s_in = '0;
    apc_sample_s s_mix = '0;
    apc_sample_s s_out;
    apc_code_wr_s code_wr;
    apc_bb_cfg_s bb;
    logic [7:0] rdata, fw_status, l_data, v;
    logic [39:0] bars;
    logic [15:0] l_addr;
    logic [6:0] cmd;
    logic run, irq, lerr;
    int failures = 0;
    int num_checks = 0;
    apc_top #(.TICK_CYCLES(8)) uut (.ref_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .fw_status_i(fw_status),
        .fw_event_i(fw_evt), .stream_status0_i(8'h11), .stream_status1_i(8'h22),
        .stream_status2_i(8'h33), .play_mode_i(mode), .buf_write_mode_i(wmode),
        .buf_empty_i(bempty), .buf_half_i(1'b0), .buf_full_i(bfull), .clip_i(clip),
        .gp_event_i(gp), .bar_levels_i(bars), .sample_i(s_in), .mix_sample_i(s_mix),
        .sample_o(s_out), .code_wr_o(code_wr), .buf_wr_o(), .buf_wdata_o(),
        .proc_run_o(run), .fw_command_o(cmd), .stream_control_o(), .bb_cfg_o(bb), .irq_o(irq));
    apc_fw_model u_fw (.ref_clk_i(clk), .reset_n_i(rst_n), .code_wr_i(code_wr),
        .fw_command_i(cmd), .proc_run_i(run), .fw_status_o(fw_status), .bar_levels_o(bars),
        .last_addr_o(l_addr), .last_data_o(l_data), .load_err_o(lerr));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task chk(input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : w
    task r(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : r
    task set_mode(input apc_mode_e m);
        @(posedge clk);
        mode <= m;
    endtask : set_mode
    task pulse(input logic c, input logic [4:0] g, input logic e);
        @(posedge clk);
        clip <= c;
        gp <= g;
        fw_evt <= e;
        @(posedge clk);
        clip <= 1'b0;
        gp <= 5'h00;
        fw_evt <= 1'b0;
        tick(3);
    endtask : pulse
    task t_load;
        w(`APC_A_PCTRL, 8'h02);
        w(`APC_A_DPORT, 8'hA5);
        w(`APC_A_PCTRL, 8'h00);
        w(`APC_A_PCTRL, 8'h02);
        w(`APC_A_DPORT, 8'h5A);
        tick(2);
        chk({l_addr, l_data}, 24'h00015A);
        w(`APC_A_PCTRL, 8'h01);
        w(`APC_A_PCTRL, 8'h02);
        w(`APC_A_DPORT, 8'h3C);
        tick(2);
        chk({l_addr, l_data}, 24'h00003C);
        w(`APC_A_PCTRL, 8'h01);
        w(`APC_A_DPORT, 8'h77);
        tick(2);
        chk({run, lerr, l_data}, 10'h23C);
        $display("t_load done");
    endtask : t_load
    task t_cmd;
        w(`APC_A_CMD, 8'hFF);
        r(`APC_A_FWSTAT, v);
        chk({cmd, v}, 15'h7FFF);
        pulse(1'b0, 5'h00, 1'b1);
        r(`APC_A_PCTRL, v);
        chk(v[7], 1'b1);
        w(`APC_A_PCTRL, 8'h81);
        r(`APC_A_PCTRL, v);
        chk(v[7], 1'b0);
        r(8'h3F, v);
        chk(v, 8'h00);
        $display("t_cmd done");
    endtask : t_cmd
    task t_time;
        w(`APC_A_TIM0, 8'h34);
        w(`APC_A_TIM1, 8'h12);
        r(`APC_A_TIM0, v);
        chk(v, 8'h00);
        w(`APC_A_TIM2, 8'h00);
        set_mode(APC_PAUSE);
        tick(40);
        r(`APC_A_TIM0, v);
        chk(v, 8'h34);
        r(`APC_A_TIM1, v);
        chk(v, 8'h12);
        w(`APC_A_TIM0, 8'hFE);
        w(`APC_A_TIM1, 8'hFF);
        w(`APC_A_TIM2, 8'h00);
        set_mode(APC_PLAY);
        r(`APC_A_TIM0, v);
        chk(v[7:1], 7'h7F);
        tick(40);
        r(`APC_A_TIM1, v);
        chk(v, 8'hFF);
        r(`APC_A_TIM2, v);
        chk(v, 8'h00);
        set_mode(APC_STOP);
        tick(2);
        set_mode(APC_PLAY);
        r(`APC_A_TIM0, v);
        chk(v[7:1], 7'h00);
        set_mode(APC_STOP);
        w(`APC_A_TIM0, 8'h00);
        w(`APC_A_TIM1, 8'h00);
        w(`APC_A_TIM2, 8'h00);
        set_mode(APC_FFWD);
        tick(40);
        r(`APC_A_TIM0, v);
        chk({v % 8'd10, v > 8'd0}, 9'h001);
        set_mode(APC_REW);
        tick(100);
        r(`APC_A_TIM0, v);
        chk(v, 8'h00);
        set_mode(APC_STOP);
        $display("t_time done");
    endtask : t_time
    task t_bb;
        logic [4:0] codes [3] = '{5'h00, 5'h1E, 5'h1F};
        chk(bb.right_vol, 5'h03);
        @(posedge clk);
        s_in <= {1'b1, 16'h1234, 16'h5678};
        tick(2);
        chk(s_out, {1'b1, 16'h1234, 16'h5678});
        w(`APC_A_BGAIN, 8'h0A);
        w(`APC_A_BBCTRL, 8'h1F);
        tick(2);
        chk({bb.vol_active, bb.eq_active, bb.boost_active, bb.surround_active,
             bb.mix_active, bb.bass_gain}, 10'h2EA);
        w(`APC_A_BBCTRL, 8'h00);
        for (int i = 0; i < 3; i++) begin
            w(`APC_A_RVOL, {3'b000, codes[i]});
            tick(2);
            chk(bb.right_vol, codes[i]);
        end
        w(`APC_A_BBCTRL, 8'h01);
        tick(3);
        chk(s_out, {1'b1, 16'h0000, 16'h5678});
        @(posedge clk);
        s_mix <= {1'b1, 16'h0010, 16'h7FFF};
        w(`APC_A_BBCTRL, 8'h11);
        tick(3);
        chk(s_out, {1'b1, 16'h0010, 16'h7FFF});
        w(`APC_A_BBCTRL, 8'h00);
        $display("t_bb done");
    endtask : t_bb
    task t_bar;
        for (int i = 0; i < 8; i++) begin
            w(`APC_A_BGSEL, 8'(i));
            r(`APC_A_BGLEV, v);
            chk(v, 8'(3 * i + 1));
        end
        $display("t_bar done");
    endtask : t_bar
    task t_irq;
        w(`APC_A_IEN, 8'hFF);
        w(`APC_A_GIEN, 8'h01);
        pulse(1'b1, 5'h00, 1'b0);
        r(`APC_A_IFLAGS, v);
        chk({irq, v[2]}, 2'b11);
        w(`APC_A_IFLAGS, 8'h04);
        tick(2);
        chk(irq, 1'b0);
        @(posedge clk);
        wmode <= 1'b1;
        r(`APC_A_IFLAGS, v);
        r(`APC_A_IFLAGS, v);
        chk({irq, v[1:0]}, 3'b101);
        @(posedge clk);
        bfull <= 1'b1;
        bempty <= 1'b0;
        tick(2);
        r(`APC_A_IFLAGS, v);
        chk(v[1:0], 2'b00);
        @(posedge clk);
        wmode <= 1'b0;
        tick(2);
        r(`APC_A_IFLAGS, v);
        chk(v[1:0], 2'b10);
        @(posedge clk);
        bfull <= 1'b0;
        bempty <= 1'b1;
        tick(2);
        r(`APC_A_IFLAGS, v);
        chk(v[1:0], 2'b00);
        w(`APC_A_IEN, 8'h08);
        pulse(1'b0, 5'h02, 1'b0);
        chk(irq, 1'b0);
        w(`APC_A_IFLAGS, 8'hF8);
        for (int k = 0; k < 5; k++) begin
            w(`APC_A_IEN, 8'h08 << k);
            pulse(1'b0, 5'h01 << k, 1'b0);
            chk(irq, 1'b1);
            w(`APC_A_IFLAGS, 8'h08 << k);
        end
        w(`APC_A_GIEN, 8'h00);
        w(`APC_A_IEN, 8'hFF);
        pulse(1'b1, 5'h00, 1'b0);
        chk(irq, 1'b0);
        $display("t_irq done");
    endtask : t_irq
    task results;
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    // Hang guard, far above the run length
    initial begin
        #500000;
        failures++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        t_bb();
        t_load();
        t_cmd();
        t_time();
        t_bar();
        t_irq();
        results();
    end
endmodule : tb_audio_processor_control
`default_nettype wire
